/* File: prpi_pkg.sv */
package prpi_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned NUM_PORTS = 3;
    localparam int unsigned PORT_P = 0;
    localparam int unsigned PORT_J = 1;
    localparam int unsigned PORT_AD = 2;
    // Register byte addresses
    localparam logic [11:0] ADDR_ROUTE = 12'h000;
    localparam logic [11:0] ADDR_IEN_BASE = 12'h010;
    localparam logic [11:0] ADDR_POL_BASE = 12'h020;
    localparam logic [11:0] ADDR_FLAG_BASE = 12'h030;
    localparam logic [11:0] ADDR_LEVEL_BASE = 12'h040;
    localparam logic [11:0] ADDR_MODE = 12'h050;
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    localparam int unsigned ROUTE_PWM_CH3_BIT = 7;
    localparam int unsigned ROUTE_PWM_CH2_BIT = 6;
    localparam int unsigned ROUTE_TIM3_HI = 5;
    localparam int unsigned ROUTE_TIM3_LO = 4;
    localparam int unsigned ROUTE_TIM2_HI = 3;
    localparam int unsigned ROUTE_TIM2_LO = 2;
    localparam int unsigned ROUTE_SER_HI = 1;
    localparam int unsigned ROUTE_SER_LO = 0;
    localparam logic [1:0] TIM3_SEL_PORT_S = 2'h0;
    localparam logic [1:0] TIM3_SEL_PORT_E = 2'h1;
    localparam logic [1:0] TIM3_SEL_ANALOG = 2'h2;
    // Filter counts
    localparam int unsigned FILT_SAMPLES = 4;
    localparam logic [2:0] FILT_CNT_MAX = 3'h4;
endpackage : prpi_pkg

/* File: prpi_filt_if.sv */
`timescale 1ns/1ps
interface prpi_filt_if #(parameter int unsigned W = 8);
    logic [W-1:0] pin;
    logic [W-1:0] pol;
    logic [W-1:0] edge_hit;
    logic [W-1:0] osc_need;
    logic sample_en;
    modport filt (input pin, input pol, input sample_en, output edge_hit, output osc_need);
    modport ctrl (output pin, output pol, output sample_en, input edge_hit, input osc_need);
endinterface : prpi_filt_if

/* File: prpi_filter.sv */
`timescale 1ns/1ps
module prpi_filter #(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    prpi_filt_if.filt fi
);
    logic [2:0] cnt_q [W];
    logic [2:0] cnt_d [W];
    logic [W-1:0] armed_q;
    logic [W-1:0] armed_d;
    logic [W-1:0] last_q;
    logic [W-1:0] last_d;
    logic [W-1:0] hit;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            logic act;
            act = fi.pin[i] == fi.pol[i];
            cnt_d[i] = cnt_q[i];
            armed_d[i] = armed_q[i];
            last_d[i] = last_q[i];
            hit[i] = 1'b0;
            if (fi.sample_en) begin
                last_d[i] = act;
                if (act != last_q[i]) begin
                    // Level change restarts the count; a full passive run arms, anything else disarms
                    armed_d[i] = act ? (cnt_q[i] >= prpi_pkg::FILT_CNT_MAX) : 1'b0;
                    cnt_d[i] = 3'h1;
                end else if (cnt_q[i] < prpi_pkg::FILT_CNT_MAX + 3'h1) begin
                    cnt_d[i] = cnt_q[i] + 3'h1;
                end
                if (act && armed_q[i] && act == last_q[i] &&
                        cnt_q[i] == prpi_pkg::FILT_CNT_MAX - 3'h1) begin
                    hit[i] = 1'b1;
                    armed_d[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < W; i++) begin
                cnt_q[i] <= 3'h0;
            end
            armed_q <= '0;
            last_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            armed_q <= armed_d;
            last_q <= last_d;
        end
    end

    assign fi.edge_hit = hit;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            // Pending level change restarts the count, so it must wake the oscillator
            fi.osc_need[i] = (cnt_q[i] <= prpi_pkg::FILT_CNT_MAX) ||
                             ((fi.pin[i] == fi.pol[i]) != last_q[i]);
        end
    end
endmodule : prpi_filter

/* File: prpi_top.sv */
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module prpi_top #(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [W-1:0] pad_p,
    input wire logic [W-1:0] pad_j,
    input wire logic [W-1:0] pad_ad,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic rc_osc_tick,
    output logic rc_osc_enable,
    output logic [prpi_pkg::NUM_PORTS-1:0] port_irq,
    output logic wakeup_req,
    output logic irq,
    output logic pwm_ch3_route_sel,
    output logic pwm_ch2_route_sel,
    output logic [1:0] timer_ch3_route,
    output logic [1:0] timer_ch2_route,
    output logic [1:0] serial0_route
);
    localparam int unsigned NP = prpi_pkg::NUM_PORTS;

    logic [7:0] route_q;
    logic [7:0] route_d;
    logic [W-1:0] ien_q [NP];
    logic [W-1:0] ien_d [NP];
    logic [W-1:0] pol_q [NP];
    logic [W-1:0] pol_d [NP];
    logic [W-1:0] flag_q [NP];
    logic [W-1:0] flag_d [NP];
    logic [W-1:0] s1_q [NP];
    logic [W-1:0] s2_q [NP];
    logic [31:0] prdata_d;
    logic pslverr_d;
    logic pready_d;
    logic [NP-1:0] pirq_d;
    logic osc_d;
    logic tick1_q;
    logic tick2_q;
    logic tick3_q;
    logic sample_en;
    logic [W-1:0] hit [NP];
    logic [W-1:0] need [NP];

    function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
        in_bank = a >= base && a < base + 12'(4 * NP) && a[1:0] == 2'h0;
    endfunction : in_bank

    function automatic int unsigned bank_idx(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        bank_idx = int'(off[11:2]);
    endfunction : bank_idx

    logic wr;
    logic rd;
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && !penable && !pwrite;

    // Pad synchronisers; the pad level is taken regardless of direction
    logic [W-1:0] pads [NP];
    assign pads[prpi_pkg::PORT_P] = pad_p;
    assign pads[prpi_pkg::PORT_J] = pad_j;
    assign pads[prpi_pkg::PORT_AD] = pad_ad;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NP; p++) begin
                s1_q[p] <= '0;
                s2_q[p] <= '0;
            end
            tick1_q <= 1'b0;
            tick2_q <= 1'b0;
            tick3_q <= 1'b0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                s1_q[p] <= pads[p];
                s2_q[p] <= s1_q[p];
            end
            tick1_q <= rc_osc_tick;
            tick2_q <= tick1_q;
            tick3_q <= tick2_q;
        end
    end

    // Bus clock rate outside stop, oscillator rising edge in stop
    assign sample_en = stop_mode ? (tick2_q && !tick3_q) : 1'b1;

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_port
            prpi_filt_if #(.W(W)) fif ();
            assign fif.pin = s2_q[g];
            assign fif.pol = pol_q[g];
            assign fif.sample_en = sample_en;
            assign hit[g] = fif.edge_hit;
            assign need[g] = fif.osc_need;
            prpi_filter #(.W(W)) u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .fi(fif.filt)
            );
        end
    endgenerate

    always_comb begin
        route_d = route_q;
        prdata_d = 32'h0;
        pslverr_d = 1'b0;
        pready_d = psel && !penable;
        osc_d = 1'b0;
        for (int p = 0; p < NP; p++) begin
            ien_d[p] = ien_q[p];
            pol_d[p] = pol_q[p];
            flag_d[p] = flag_q[p];
            if (wr && pstrb[0] && in_bank(paddr, prpi_pkg::ADDR_FLAG_BASE) &&
                    bank_idx(paddr, prpi_pkg::ADDR_FLAG_BASE) == p) begin
                flag_d[p] = flag_q[p] & ~pwdata[W-1:0];
            end
            flag_d[p] = flag_d[p] | hit[p];
            pirq_d[p] = |(flag_d[p] & ien_q[p]);
            osc_d = osc_d | (|(ien_q[p] & ~flag_q[p] & need[p]));
        end
        if (wr && pstrb[0]) begin
            if (paddr == prpi_pkg::ADDR_ROUTE) begin
                route_d = pwdata[7:0];
            end else if (in_bank(paddr, prpi_pkg::ADDR_IEN_BASE)) begin
                ien_d[bank_idx(paddr, prpi_pkg::ADDR_IEN_BASE)] = pwdata[W-1:0];
            end else if (in_bank(paddr, prpi_pkg::ADDR_POL_BASE)) begin
                pol_d[bank_idx(paddr, prpi_pkg::ADDR_POL_BASE)] = pwdata[W-1:0];
            end
        end
        if (psel && !penable) begin
            if (paddr == prpi_pkg::ADDR_ROUTE) begin
                prdata_d[7:0] = route_q;
            end else if (in_bank(paddr, prpi_pkg::ADDR_IEN_BASE)) begin
                prdata_d[W-1:0] = ien_q[bank_idx(paddr, prpi_pkg::ADDR_IEN_BASE)];
            end else if (in_bank(paddr, prpi_pkg::ADDR_POL_BASE)) begin
                prdata_d[W-1:0] = pol_q[bank_idx(paddr, prpi_pkg::ADDR_POL_BASE)];
            end else if (in_bank(paddr, prpi_pkg::ADDR_FLAG_BASE)) begin
                prdata_d[W-1:0] = flag_q[bank_idx(paddr, prpi_pkg::ADDR_FLAG_BASE)];
            end else if (in_bank(paddr, prpi_pkg::ADDR_LEVEL_BASE)) begin
                prdata_d[W-1:0] = s2_q[bank_idx(paddr, prpi_pkg::ADDR_LEVEL_BASE)];
            end else if (paddr == prpi_pkg::ADDR_MODE) begin
                prdata_d[1:0] = {wait_mode, stop_mode};
            end else begin
                pslverr_d = 1'b1;
            end
            if (!rd) begin
                prdata_d = 32'h0;
            end
        end else begin
            prdata_d = prdata;
            pslverr_d = pslverr && psel;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_q <= prpi_pkg::ROUTE_RESET;
            for (int p = 0; p < NP; p++) begin
                ien_q[p] <= '0;
                pol_q[p] <= '0;
                flag_q[p] <= '0;
            end
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            port_irq <= '0;
            irq <= 1'b0;
            wakeup_req <= 1'b0;
            rc_osc_enable <= 1'b0;
        end else begin
            route_q <= route_d;
            ien_q <= ien_d;
            pol_q <= pol_d;
            flag_q <= flag_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            port_irq <= pirq_d;
            irq <= |pirq_d;
            wakeup_req <= |pirq_d && (stop_mode || wait_mode);
            rc_osc_enable <= osc_d && stop_mode;
        end
    end

    always_comb begin
        pwm_ch3_route_sel = route_q[prpi_pkg::ROUTE_PWM_CH3_BIT];
        pwm_ch2_route_sel = route_q[prpi_pkg::ROUTE_PWM_CH2_BIT];
        timer_ch3_route = route_q[prpi_pkg::ROUTE_TIM3_HI:prpi_pkg::ROUTE_TIM3_LO];
        timer_ch2_route = route_q[prpi_pkg::ROUTE_TIM2_HI:prpi_pkg::ROUTE_TIM2_LO];
        serial0_route = route_q[prpi_pkg::ROUTE_SER_HI:prpi_pkg::ROUTE_SER_LO];
    end
endmodule : prpi_top

/* File: prpi_pins.sv */
`timescale 1ns/1ps
module prpi_pins (
    input wire logic osc_en,
    output logic tick
);
    // Stop-mode sample oscillator, unrelated in phase to pclk; it halts when not asked for
    initial tick = 1'b0;
    always begin
        #37;
        tick = osc_en ? ~tick : 1'b0;
    end
endmodule : prpi_pins

/* File: prpi_top_sva.sv */
`timescale 1ns/1ps
module prpi_top_sva #(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic rc_osc_enable,
    input wire logic [prpi_pkg::NUM_PORTS-1:0] port_irq,
    input wire logic wakeup_req,
    input wire logic irq,
    input wire logic pwm_ch3_route_sel,
    input wire logic pwm_ch2_route_sel,
    input wire logic [1:0] timer_ch3_route,
    input wire logic [1:0] timer_ch2_route,
    input wire logic [1:0] serial0_route
);
    logic [7:0] route_q;
    logic wr_route;
    assign wr_route = psel && penable && pready && pwrite && pstrb[0]
        && (paddr == prpi_pkg::ADDR_ROUTE);
    // Reference copy of the routing register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) route_q <= prpi_pkg::ROUTE_RESET;
        else if (wr_route) route_q <= pwdata[7:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pwm_ch3_route_a: assert property (pwm_ch3_route_sel == route_q[7])
        else $error("pwm channel 3 route bit wrong");
    pwm_ch2_route_a: assert property (pwm_ch2_route_sel == route_q[6])
        else $error("pwm channel 2 route bit wrong");
    tim3_route_a: assert property (timer_ch3_route == route_q[5:4])
        else $error("timer3 route field wrong");
    tim2_route_a: assert property (timer_ch2_route == route_q[3:2])
        else $error("timer2 route field wrong");
    ser_route_a: assert property (serial0_route == route_q[1:0])
        else $error("serial route field wrong");
    irq_quiet_a: assert property ((port_irq == 3'h0) [*2] |-> !irq)
        else $error("irq without port request");
    irq_merge_a: assert property ($rose(port_irq[0]) |-> ##[0:2] irq)
        else $error("port request not merged");
    wake_mode_a: assert property (!(stop_mode || wait_mode) [*2] |-> !wakeup_req)
        else $error("wakeup outside stop or wait");
    osc_stop_a: assert property (!stop_mode [*2] |-> !rc_osc_enable)
        else $error("oscillator on outside stop");
    cover property (wr_route);
    cover property ($rose(irq));
    cover property ($rose(wakeup_req) && stop_mode);
    cover property ($rose(rc_osc_enable));
endmodule : prpi_top_sva
bind prpi_top prpi_top_sva #(.W(W)) sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .rc_osc_enable(rc_osc_enable), .port_irq(port_irq), .wakeup_req(wakeup_req), .irq(irq),
    .pwm_ch3_route_sel(pwm_ch3_route_sel), .pwm_ch2_route_sel(pwm_ch2_route_sel),
    .timer_ch3_route(timer_ch3_route), .timer_ch2_route(timer_ch2_route),
    .serial0_route(serial0_route));

/* File: port_routing_and_pin_interrupt_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module port_routing_and_pin_interrupt_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [7:0] pads [3] = '{8'h00, 8'h00, 8'h00};
    logic stop_mode = 1'b0, wait_mode = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rc_osc_tick, rc_osc_enable, wakeup_req, irq, er, p3, p2;
    logic [2:0] port_irq;
    logic [1:0] t3, t2, s0;
    int errors = 0;
    int checks = 0;
    always #4 pclk = ~pclk;
    prpi_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_p(pads[0]), .pad_j(pads[1]),
        .pad_ad(pads[2]), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .rc_osc_tick(rc_osc_tick), .rc_osc_enable(rc_osc_enable), .port_irq(port_irq),
        .wakeup_req(wakeup_req), .irq(irq), .pwm_ch3_route_sel(p3), .pwm_ch2_route_sel(p2),
        .timer_ch3_route(t3), .timer_ch2_route(t2), .serial0_route(s0));
    prpi_pins pins_u (.osc_en(rc_osc_enable), .tick(rc_osc_tick));
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic regs();
        apb(1'b0, prpi_pkg::ADDR_ROUTE, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, prpi_pkg::ADDR_IEN_BASE + 12'h008, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, prpi_pkg::ADDR_IEN_BASE + 12'h00C, 32'h0);
        `CHK(er, 1'b1)
        apb(1'b0, prpi_pkg::ADDR_LEVEL_BASE + 12'h004, 32'h0);
        `CHK(rd, 32'h0)
    endtask : regs
    task automatic route();
        logic [7:0] v [9] = '{8'h80, 8'h40, 8'h10, 8'h20, 8'h04, 8'h0B, 8'h0D, 8'hC2, 8'h00};
        foreach (v[i]) begin
            apb(1'b1, prpi_pkg::ADDR_ROUTE, {24'h0, v[i]});
            apb(1'b0, prpi_pkg::ADDR_ROUTE, 32'h0);
            `CHK(rd, {24'h0, v[i]})
            `CHK(p3, v[i][7])
            `CHK(p2, v[i][6])
            `CHK(t3, v[i][5:4])
            `CHK(t2, v[i][3:2])
            `CHK(s0, v[i][1:0])
        end
    endtask : route
    task automatic glitch();
        apb(1'b1, prpi_pkg::ADDR_POL_BASE, 32'h02);
        apb(1'b1, prpi_pkg::ADDR_IEN_BASE, 32'h02);
        apb(1'b1, prpi_pkg::ADDR_FLAG_BASE, 32'hFF);
        pads[0][1] <= 1'b1;
        repeat (3) @(posedge pclk);
        pads[0][1] <= 1'b0;
        repeat (20) @(posedge pclk);
        `CHK(port_irq, 3'h0)
        pads[0][1] <= 1'b1;
        repeat (4) @(posedge pclk);
        pads[0][1] <= 1'b0;
        repeat (20) @(posedge pclk);
        `CHK(port_irq, 3'h1)
        apb(1'b1, prpi_pkg::ADDR_IEN_BASE, 32'h0);
    endtask : glitch
    task automatic pin_edge(input int p, input int b, input logic rise);
        logic [11:0] o;
        logic [7:0] m;
        int n;
        o = 12'(4 * p);
        m = 8'h01 << b;
        n = 0;
        pads[p][b] <= ~rise;
        apb(1'b1, prpi_pkg::ADDR_POL_BASE + o, {24'h0, rise ? m : 8'h00});
        apb(1'b1, prpi_pkg::ADDR_IEN_BASE + o, {24'h0, m});
        repeat (80) @(posedge pclk);
        // Drop flags raised by the polarity change itself
        apb(1'b1, prpi_pkg::ADDR_FLAG_BASE + o, 32'hFF);
        pads[p][b] <= rise;
        repeat (5) @(posedge pclk);
        `CHK(rc_osc_enable, stop_mode)
        while (port_irq[p] !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        `CHK(port_irq, 3'(1 << p))
        `CHK(irq, 1'b1)
        `CHK(wakeup_req, stop_mode | wait_mode)
        `CHK(rc_osc_enable, 1'b0)
        apb(1'b0, prpi_pkg::ADDR_FLAG_BASE + o, 32'h0);
        `CHK(rd[7:0], m)
        apb(1'b0, prpi_pkg::ADDR_LEVEL_BASE + o, 32'h0);
        `CHK(rd[b], rise)
        apb(1'b0, prpi_pkg::ADDR_MODE, 32'h0);
        `CHK(rd, {30'h0, wait_mode, stop_mode})
        apb(1'b1, prpi_pkg::ADDR_FLAG_BASE + o, {24'h0, m});
        repeat (2) @(posedge pclk);
        `CHK(port_irq, 3'h0)
        apb(1'b1, prpi_pkg::ADDR_IEN_BASE + o, 32'h0);
    endtask : pin_edge
    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs();
        route();
        glitch();
        pin_edge(0, 0, 1'b1);
        pin_edge(1, 7, 1'b0);
        pin_edge(2, 3, 1'b1);
        wait_mode <= 1'b1;
        pin_edge(0, 2, 1'b0);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        pin_edge(2, 5, 1'b1);
        stop_mode <= 1'b0;
        tally_and_finish();
    end
endmodule : port_routing_and_pin_interrupt_bench
